// ==== hdl/encoder_od_consts.vh ====
`ifndef ENCODER_OD_CONSTS_VH
`define ENCODER_OD_CONSTS_VH

// Object indices
`define IDX_OPER 16'h6000
`define IDX_STEPS 16'h6001
`define IDX_RANGE 16'h6002
`define IDX_PRESET 16'h6003
`define IDX_POS 16'h6004
`define IDX_WIDE 16'h6008
`define IDX_SPEED 16'h6030
`define IDX_ACCEL 16'h6040
`define IDX_CYCLE 16'h6200
`define IDX_CAM_STATE 16'h6300
`define IDX_CAM_EN 16'h6301
`define IDX_VEND_POS 16'h2000
`define IDX_VEND_CFG 16'h2100
`define IDX_VEND_STEPS 16'h2101
`define IDX_VEND_PRESET 16'h2103
`define IDX_VEND_CYCLE 16'h2200
`define IDX_VEND_SPEED32 16'h3010
`define IDX_TPDO1 16'h1800

// Subindices
`define SUB_VALUE 8'h00
`define SUB_CH1 8'h01
`define SUB_EVT_TIMER 8'h05
`define SUB_LAST_CH 8'hfe
`define SUB_COUNT 8'h01

// Operating word fields
`define OPER_DIR_BIT 0
`define OPER_SCALE_BIT 2

// Reset values
`define OPER_RST 16'h0000
`define PRESET_RST 32'h00000000
`define CYCLE_RST 16'h0064
`define CAM_STATE_RST 8'h04
`define CAM_EN_RST 8'h00

// Timing
`define CLK_PERIOD_NS 50
`define MS_NS 1000000
`define CYC_PER_MS (`MS_NS / `CLK_PERIOD_NS)

`endif

// ==== hdl/range_remainder.v ====
`timescale 1ns/100ps
// Sequential 64 by 32 remainder, one quotient bit per cycle
module range_remainder (
   input wire clock,
   input wire rst,
   input wire start,
   input wire [63:0] dividend,
   input wire [31:0] divisor,
   output reg busy,
   output reg done,
   output reg [31:0] remainder
);
   reg [63:0] shift_reg;
   reg [32:0] part_reg;
   reg [6:0] count_reg;
   reg [31:0] div_reg;
   wire [32:0] trial;
   wire [32:0] diff;

   assign trial = {part_reg[31:0], shift_reg[63]};
   assign diff = trial - {1'b0, div_reg};

   always @(posedge clock) begin
      if (rst) begin
         busy <= 1'b0;
         done <= 1'b0;
         remainder <= 32'h00000000;
         shift_reg <= 64'h0000000000000000;
         part_reg <= 33'h000000000;
         count_reg <= 7'h00;
         div_reg <= 32'h00000000;
      end else begin
         done <= 1'b0;
         if (!busy && start) begin
            busy <= 1'b1;
            shift_reg <= dividend;
            div_reg <= divisor;
            part_reg <= 33'h000000000;
            count_reg <= 7'h40;
         end else if (busy) begin
            shift_reg <= {shift_reg[62:0], 1'b0};
            if (!diff[32]) begin
               part_reg <= diff;
            end else begin
               part_reg <= trial;
            end
            count_reg <= count_reg - 7'h01;
            if (count_reg == 7'h01) begin
               busy <= 1'b0;
               done <= 1'b1;
               remainder <= !diff[32] ? diff[31:0] : trial[31:0];
            end
         end
      end
   end
endmodule

// ==== hdl/encoder_position_object_set.v ====
`timescale 1ns/100ps
`include "encoder_od_consts.vh"

// Functional notes
// - Scaling applied only when scale_enable is 1
// - Direction bit 0 counts up clockwise
// - Direction bit shared with config object bit0
// - Unused operating bits have no effect
// - Steps per turn, 32-bit rw, factory default
// - Total range, 32-bit rw register
// - Preset, 32-bit rw, default zero
// - Position object aliases vendor position object
// - 64-bit wide position, 16/31 bit resolution
// - 32-bit multiturn variant: no preset, no scaling
// - Wide position ignores total range
// - Wide position uses steps per turn
// - Preset sets wide position within 32 bits
// - Speed saturates to signed 16 bits
// - Acceleration signed 16-bit read-only
// - Cycle period 16-bit ms, default 64h
// - Cycle period shared with the TPDO1 event timer object (1800h sub 5)
// - Cam states read-only, channels 1 to 254
// - Cam enable 8-bit rw for channel 1
// - Operating word 16-bit rw, default zero
module encoder_position_object_set #(
   parameter TURN_BITS = 31,
   parameter [31:0] FACTORY_STEPS = 32'h00010000,
   parameter [31:0] FACTORY_RANGE = 32'h80000000,
   parameter [31:0] CYCLES_PER_MS = `CYC_PER_MS
) (
   input wire clock,
   input wire rst,
   input wire [15:0] sensor_single,
   input wire [TURN_BITS-1:0] sensor_turns,
   input wire signed [31:0] sensor_speed,
   input wire signed [15:0] sensor_accel,
   input wire cam_update,
   input wire [7:0] cam_hits,
   input wire od_req,
   input wire od_write,
   input wire [15:0] od_index,
   input wire [7:0] od_sub,
   input wire [31:0] od_wdata,
   output reg od_ack,
   output reg od_abort,
   output reg [63:0] od_rdata,
   output reg [31:0] process_position,
   output reg [63:0] wide_position,
   output reg [15:0] speed_out,
   output reg cycle_tick
);
   localparam NATIVE_W = 16 + TURN_BITS;
   // Full 32-bit multiturn variant loses preset and scaling
   localparam FEATURES = (TURN_BITS < 32) ? 1'b1 : 1'b0;

   reg [15:0] oper_reg;
   reg [31:0] steps_reg;
   reg [31:0] range_reg;
   reg [31:0] preset_reg;
   reg [15:0] cycle_reg;
   reg [7:0] cam_state_reg;
   reg [7:0] cam_en_reg;
   reg [31:0] base_reg;
   reg [31:0] offset_reg;
   reg [63:0] wide_off_reg;
   reg [31:0] ms_cnt_reg;
   reg [15:0] period_cnt_reg;
   reg div_start_reg;
   reg ms_en_reg;

   wire ccw_up;
   wire scale_on;
   wire [NATIVE_W-1:0] native_raw;
   wire [NATIVE_W-1:0] native;
   wire [63:0] turn_prod;
   wire [47:0] frac_prod;
   wire [63:0] full_pos;
   wire [63:0] unscaled_pos;
   wire [63:0] pos_used;
   wire [32:0] eff_range;
   wire [32:0] sum;
   wire [31:0] wrapped;
   wire [31:0] base_now;
   wire [31:0] offset_new;
   wire [31:0] preset_reg_in;
   wire div_busy;
   wire div_done;
   wire [31:0] div_rem;
   wire [15:0] speed_sat;

   assign ccw_up = oper_reg[`OPER_DIR_BIT];
   assign scale_on = oper_reg[`OPER_SCALE_BIT] & FEATURES;

   assign native_raw = {sensor_turns, sensor_single};
   assign native = ccw_up ? ~native_raw : native_raw;
   // Scaled value: turns * steps plus fractional turn * steps
   assign turn_prod = {{(64-TURN_BITS){1'b0}}, native[NATIVE_W-1:16]} * {32'h00000000, steps_reg};
   assign frac_prod = {32'h00000000, native[15:0]} * {16'h0000, steps_reg};
   assign full_pos = turn_prod + {32'h00000000, frac_prod[47:16]};
   assign unscaled_pos = {{(64-NATIVE_W){1'b0}}, native};
   assign pos_used = scale_on ? full_pos : unscaled_pos;

   // Total range only shapes the 32-bit process value
   assign eff_range = scale_on ? {1'b0, range_reg} : 33'h100000000;
   assign base_now = scale_on ? base_reg : pos_used[31:0];
   assign sum = {1'b0, base_now} + {1'b0, offset_reg};
   assign wrapped = (sum >= eff_range) ? sum[31:0] - eff_range[31:0] : sum[31:0];
   assign offset_new = (preset_reg_in >= base_now) ? preset_reg_in - base_now
                       : preset_reg_in + eff_range[31:0] - base_now;

   assign speed_sat = (sensor_speed > 32'sd32767) ? 16'h7fff :
                      (sensor_speed < -32'sd32768) ? 16'h8000 :
                      sensor_speed[15:0];

   range_remainder u_rem (
      .clock(clock),
      .rst(rst),
      .start(div_start_reg),
      .dividend(full_pos),
      .divisor(range_reg),
      .busy(div_busy),
      .done(div_done),
      .remainder(div_rem)
   );

   // Decode of object accesses
   wire is_oper;
   wire is_cfg;
   wire is_steps;
   wire is_range;
   wire is_preset;
   wire is_pos;
   wire is_wide;
   wire is_speed;
   wire is_speed32;
   wire is_accel;
   wire is_cycle;
   wire is_cam_st;
   wire is_cam_en;
   wire is_count;
   wire wr_ok;
   reg [63:0] rd_val;
   reg rd_hit;
   reg rw_hit;

   assign is_oper = od_index == `IDX_OPER && od_sub == `SUB_VALUE;
   assign is_cfg = od_index == `IDX_VEND_CFG && od_sub == `SUB_VALUE;
   assign is_steps = (od_index == `IDX_STEPS || od_index == `IDX_VEND_STEPS)
                     && od_sub == `SUB_VALUE;
   assign is_range = od_index == `IDX_RANGE && od_sub == `SUB_VALUE;
   assign is_preset = (od_index == `IDX_PRESET || od_index == `IDX_VEND_PRESET)
                      && od_sub == `SUB_VALUE;
   assign is_pos = (od_index == `IDX_POS || od_index == `IDX_VEND_POS)
                   && od_sub == `SUB_VALUE;
   assign is_wide = od_index == `IDX_WIDE && od_sub == `SUB_VALUE;
   assign is_speed = od_index == `IDX_SPEED && od_sub == `SUB_CH1;
   assign is_speed32 = od_index == `IDX_VEND_SPEED32 && od_sub == `SUB_VALUE;
   assign is_accel = od_index == `IDX_ACCEL && od_sub == `SUB_CH1;
   assign is_cycle = ((od_index == `IDX_CYCLE || od_index == `IDX_VEND_CYCLE)
                      && od_sub == `SUB_VALUE)
                     || (od_index == `IDX_TPDO1 && od_sub == `SUB_EVT_TIMER);
   assign is_cam_st = od_index == `IDX_CAM_STATE && od_sub >= `SUB_CH1
                      && od_sub <= `SUB_LAST_CH;
   assign is_cam_en = od_index == `IDX_CAM_EN && od_sub == `SUB_CH1;
   assign is_count = od_sub == `SUB_VALUE && (od_index == `IDX_SPEED ||
                     od_index == `IDX_ACCEL || od_index == `IDX_CAM_STATE ||
                     od_index == `IDX_CAM_EN);
   assign preset_reg_in = od_wdata;

   always @* begin
      rd_val = 64'h0000000000000000;
      rd_hit = 1'b1;
      rw_hit = 1'b0;
      if (is_oper) begin
         rd_val = {48'h000000000000, oper_reg};
         rw_hit = 1'b1;
      end else if (is_cfg) begin
         rd_val = {63'h0000000000000000, ccw_up};
         rw_hit = 1'b1;
      end else if (is_steps) begin
         rd_val = {32'h00000000, steps_reg};
         rw_hit = 1'b1;
      end else if (is_range) begin
         rd_val = {32'h00000000, range_reg};
         rw_hit = 1'b1;
      end else if (is_preset) begin
         rd_val = {32'h00000000, preset_reg};
         rw_hit = 1'b1;
      end else if (is_pos) begin
         rd_val = {32'h00000000, process_position};
      end else if (is_wide) begin
         rd_val = wide_position;
      end else if (is_speed) begin
         rd_val = {48'h000000000000, speed_out};
      end else if (is_speed32) begin
         rd_val = {32'h00000000, sensor_speed};
      end else if (is_accel) begin
         rd_val = {48'h000000000000, sensor_accel};
      end else if (is_cycle) begin
         rd_val = {48'h000000000000, cycle_reg};
         rw_hit = 1'b1;
      end else if (is_cam_st) begin
         rd_val = (od_sub == `SUB_CH1) ? {56'h00000000000000, cam_state_reg}
                  : 64'h0000000000000000;
      end else if (is_cam_en) begin
         rd_val = {56'h00000000000000, cam_en_reg};
         rw_hit = 1'b1;
      end else if (is_count) begin
         rd_val = {56'h00000000000000, `SUB_COUNT};
      end else begin
         rd_hit = 1'b0;
      end
   end

   // Zero period, zero resolution and out-of-range presets are refused
   assign wr_ok = rw_hit
                  && !(is_cycle && od_wdata[15:0] == 16'h0000)
                  && !((is_steps || is_range) && od_wdata == 32'h00000000)
                  && !(is_preset && (!FEATURES ||
                       (scale_on && {1'b0, od_wdata} >= eff_range)));

   always @(posedge clock) begin
      if (rst) begin
         od_ack <= 1'b0;
         od_abort <= 1'b0;
         od_rdata <= 64'h0000000000000000;
         oper_reg <= `OPER_RST;
         steps_reg <= FACTORY_STEPS;
         range_reg <= FACTORY_RANGE;
         preset_reg <= `PRESET_RST;
         cycle_reg <= `CYCLE_RST;
         cam_en_reg <= `CAM_EN_RST;
         offset_reg <= 32'h00000000;
         wide_off_reg <= 64'h0000000000000000;
      end else begin
         od_ack <= od_req;
         od_abort <= 1'b0;
         if (od_req) begin
            od_rdata <= od_write ? 64'h0000000000000000 : rd_val;
            if (!od_write) begin
               od_abort <= !rd_hit;
            end else if (!wr_ok) begin
               od_abort <= 1'b1;
            end else begin
               if (is_oper) begin
                  oper_reg <= od_wdata[15:0];
                  // Offset of one frame is no use in the other
                  if (od_wdata[`OPER_SCALE_BIT] != oper_reg[`OPER_SCALE_BIT]) begin
                     offset_reg <= 32'h00000000;
                  end
               end
               if (is_cfg) begin
                  oper_reg[`OPER_DIR_BIT] <= od_wdata[0];
               end
               if (is_steps) begin
                  steps_reg <= od_wdata;
               end
               if (is_range) begin
                  range_reg <= od_wdata;
                  // Keep the offset below a smaller range
                  if (offset_reg >= od_wdata) begin
                     offset_reg <= 32'h00000000;
                  end
               end
               if (is_cycle) begin
                  cycle_reg <= od_wdata[15:0];
               end
               if (is_cam_en) begin
                  cam_en_reg <= od_wdata[7:0];
               end
               if (is_preset) begin
                  preset_reg <= od_wdata;
                  offset_reg <= offset_new;
                  wide_off_reg <= {32'h00000000, od_wdata} - pos_used;
               end
            end
         end
      end
   end

   // Remainder against total range is refreshed continuously while scaling is on
   always @(posedge clock) begin
      if (rst) begin
         div_start_reg <= 1'b0;
         base_reg <= 32'h00000000;
      end else begin
         div_start_reg <= scale_on && !div_busy && !div_start_reg;
         if (div_done) begin
            base_reg <= div_rem;
         end
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         process_position <= 32'h00000000;
         wide_position <= 64'h0000000000000000;
         speed_out <= 16'h0000;
         cam_state_reg <= `CAM_STATE_RST;
      end else begin
         process_position <= wrapped;
         wide_position <= pos_used + wide_off_reg;
         speed_out <= speed_sat;
         if (cam_update) begin
            cam_state_reg <= cam_hits & cam_en_reg;
         end
      end
   end

   // Millisecond enable pulse from a divider
   always @(posedge clock) begin
      if (rst) begin
         ms_cnt_reg <= 32'h00000000;
         ms_en_reg <= 1'b0;
      end else begin
         ms_en_reg <= 1'b0;
         if (ms_cnt_reg >= CYCLES_PER_MS - 32'h00000001) begin
            ms_cnt_reg <= 32'h00000000;
            ms_en_reg <= 1'b1;
         end else begin
            ms_cnt_reg <= ms_cnt_reg + 32'h00000001;
         end
      end
   end

   // Cyclic transmit period counted in milliseconds
   always @(posedge clock) begin
      if (rst) begin
         period_cnt_reg <= 16'h0000;
         cycle_tick <= 1'b0;
      end else begin
         cycle_tick <= 1'b0;
         if (ms_en_reg) begin
            if (period_cnt_reg >= cycle_reg - 16'h0001) begin
               period_cnt_reg <= 16'h0000;
               cycle_tick <= 1'b1;
            end else begin
               period_cnt_reg <= period_cnt_reg + 16'h0001;
            end
         end
      end
   end
endmodule

// ==== tb/encoder_checker_props.sv ====
`timescale 1ns/100ps
module encoder_checker #(
   parameter TURN_BITS = 31
) (
   input wire clock,
   input wire rst,
   input wire [15:0] sensor_single,
   input wire [TURN_BITS-1:0] sensor_turns,
   input wire signed [31:0] sensor_speed,
   input wire signed [15:0] sensor_accel,
   input wire cam_update,
   input wire [7:0] cam_hits,
   input wire od_req,
   input wire od_write,
   input wire [15:0] od_index,
   input wire [7:0] od_sub,
   input wire [31:0] od_wdata,
   input wire od_ack,
   input wire od_abort,
   input wire [63:0] od_rdata,
   input wire [31:0] process_position,
   input wire [63:0] wide_position,
   input wire [15:0] speed_out,
   input wire cycle_tick
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   a_ack_follows_req: assert property (od_ack == $past(od_req))
      else $error("answer not one cycle after request");
   a_write_rdata_zero: assert property (od_ack && $past(od_write) |-> od_rdata == 64'h0)
      else $error("read data not zero after write");
   a_ro_write_abort: assert property (
      od_req && od_write && (od_index == 16'h6004 || od_index == 16'h2000
      || od_index == 16'h6008) |=> od_abort) else $error("position write accepted");
   a_cam_state_ro: assert property (
      od_req && od_write && od_index == 16'h6300 |=> od_ack && od_abort)
      else $error("cam state write accepted");
   a_unknown_read_abort: assert property (
      od_req && !od_write && od_index[15:12] == 4'h5 |=> od_abort)
      else $error("unknown object read accepted");
   a_zero_period_abort: assert property (
      od_req && od_write && (od_index == 16'h6200 || od_index == 16'h2200
      || (od_index == 16'h1800 && od_sub == 8'h05)) && od_wdata[15:0] == 16'h0 |=> od_abort)
      else $error("zero period accepted");
   a_zero_steps_abort: assert property (
      od_req && od_write && od_index == 16'h6001 && od_wdata == 32'h0 |=> od_abort)
      else $error("zero steps accepted");
   a_speed_sat_high: assert property (
      (sensor_speed > 32'sd32767) [*3] |-> speed_out == 16'h7fff)
      else $error("speed not held at top");
   a_speed_sat_low: assert property (
      (sensor_speed < -32'sd32768) [*3] |-> speed_out == 16'h8000)
      else $error("speed not held at bottom");
   a_tick_is_pulse: assert property (cycle_tick |=> !cycle_tick)
      else $error("cycle tick longer than one clock");
endmodule

// ==== tb/od_master_model.sv ====
`timescale 1ns/100ps
module od_master_model (
   input wire clock,
   input wire od_ack,
   input wire od_abort,
   input wire [63:0] od_rdata,
   output logic od_req,
   output logic od_write,
   output logic [15:0] od_index,
   output logic [7:0] od_sub,
   output logic [31:0] od_wdata
);
   initial begin
      od_req = 1'b0;
      od_write = 1'b0;
      od_index = 16'h0;
      od_sub = 8'h0;
      od_wdata = 32'h0;
   end
   // One request pulse; the answer stands in the cycle after it is taken
   task automatic access(input logic w, input logic [15:0] ix, input logic [7:0] sb,
         input logic [31:0] d, output logic [63:0] rd, output logic ak, output logic ab);
      @(posedge clock);
      #1;
      {od_req, od_write, od_index, od_sub, od_wdata} = {1'b1, w, ix, sb, d};
      @(posedge clock);
      #1;
      // Released qualifiers no longer show the old request
      {od_req, od_write, od_index, od_sub, od_wdata} = {1'b0, ~w, ~ix, ~sb, ~d};
      {rd, ak, ab} = {od_rdata, od_ack, od_abort};
   endtask
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
module testbench;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [15:0] sensor_single = 16'h1234;
   logic [30:0] sensor_turns = 31'h5;
   logic signed [31:0] sensor_speed = 32'sh0;
   logic signed [15:0] sensor_accel = 16'shfedc;
   logic cam_update = 1'b0;
   logic [7:0] cam_hits = 8'h0;
   wire od_req, od_write, od_ack, od_abort, cycle_tick;
   wire [15:0] od_index, speed_out;
   wire [7:0] od_sub;
   wire [31:0] od_wdata, process_position;
   wire [63:0] od_rdata, wide_position;
   logic [63:0] rv;
   int err_total = 0;
   int checks = 0;
   int cyc = 0;
   always #25 clock = ~clock;
   od_master_model u_od_master (.clock(clock), .od_ack(od_ack), .od_abort(od_abort),
      .od_rdata(od_rdata), .od_req(od_req), .od_write(od_write), .od_index(od_index),
      .od_sub(od_sub), .od_wdata(od_wdata));
   encoder_position_object_set #(.TURN_BITS(31), .CYCLES_PER_MS(32'd4))
      u_encoder_position_object_set (.clock(clock), .rst(rst), .sensor_single(sensor_single),
      .sensor_turns(sensor_turns), .sensor_speed(sensor_speed), .sensor_accel(sensor_accel),
      .cam_update(cam_update), .cam_hits(cam_hits), .od_req(od_req), .od_write(od_write),
      .od_index(od_index), .od_sub(od_sub), .od_wdata(od_wdata), .od_ack(od_ack),
      .od_abort(od_abort), .od_rdata(od_rdata), .process_position(process_position),
      .wide_position(wide_position), .speed_out(speed_out), .cycle_tick(cycle_tick));
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [15:0] ix, input logic [7:0] sb,
         input logic [31:0] d, input logic eab);
      logic ak;
      logic ab;
      u_od_master.access(w, ix, sb, d, rv, ak, ab);
      chk({ak, ab}, {1'b1, eab});
   endtask
   task automatic rdc(input logic [15:0] ix, input logic [7:0] sb, input logic [63:0] exp,
         input logic [63:0] m = 64'hffffffff);
      acc(1'b0, ix, sb, 32'h0, 1'b0);
      chk(rv & m, exp);
   endtask
   task automatic wr(input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] d,
         input logic eab = 1'b0);
      acc(1'b1, ix, sb, d, eab);
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic t_defaults;
      logic [15:0] ix[8] = '{16'h6000, 16'h6003, 16'h6200, 16'h6300, 16'h6301, 16'h6001,
         16'h6002, 16'h6300};
      logic [7:0] sb[8] = '{8'h0, 8'h0, 8'h0, 8'h1, 8'h1, 8'h0, 8'h0, 8'hfe};
      logic [63:0] ex[8] = '{64'h0, 64'h0, 64'h64, 64'h4, 64'h0, 64'h10000, 64'h80000000, 0};
      for (int i = 0; i < 8; i++) begin
         rdc(ix[i], sb[i], ex[i]);
      end
   endtask
   task automatic t_direction;
      chk(process_position, 64'h51234);
      rdc(16'h2000, 8'h0, 64'h51234);
      rdc(16'h6004, 8'h0, 64'h51234);
      wr(16'h2100, 8'h0, 32'h1);
      step(3);
      chk(process_position, 64'hfffaedcb);
      rdc(16'h6000, 8'h0, 64'h1, 64'h1);
      wr(16'h6000, 8'h0, 32'hf00a);
      step(3);
      chk(process_position, 64'h51234);
      rdc(16'h2100, 8'h0, 64'h0, 64'h1);
      rdc(16'h6000, 8'h0, 64'hf00a, 64'hffff);
   endtask
   task automatic t_scaling;
      sensor_single = 16'h8000;
      wr(16'h6001, 8'h0, 32'h100);
      wr(16'h6000, 8'h0, 32'h4);
      step(200);
      chk(process_position, 64'h580);
      chk(wide_position, 64'h580);
      wr(16'h6002, 8'h0, 32'h100);
      step(200);
      chk(process_position, 64'h80);
      chk(wide_position, 64'h580);
      wr(16'h6001, 8'h0, 32'h0, 1'b1);
      rdc(16'h6001, 8'h0, 64'h100);
      rdc(16'h2101, 8'h0, 64'h100);
      wr(16'h6003, 8'h0, 32'h100, 1'b1);
      wr(16'h6000, 8'h0, 32'h0);
      step(3);
      chk(process_position, 64'h58000);
   endtask
   task automatic t_preset;
      wr(16'h6003, 8'h0, 32'h1000);
      step(3);
      chk(process_position, 64'h1000);
      chk(wide_position, 64'h1000);
      sensor_single = 16'h8010;
      step(3);
      chk(process_position, 64'h1010);
      rdc(16'h2103, 8'h0, 64'h1000);
      rdc(16'h6008, 8'h0, 64'h1010, '1);
   endtask
   task automatic t_speed;
      logic signed [31:0] sp[4] = '{32'sh12345, -32'sh12345, 32'sh123, -32'sh8000};
      logic [15:0] ex[4] = '{16'h7fff, 16'h8000, 16'h0123, 16'h8000};
      for (int i = 0; i < 4; i++) begin
         sensor_speed = sp[i];
         step(3);
         chk(speed_out, ex[i]);
         rdc(16'h6030, 8'h1, ex[i], 64'hffff);
         rdc(16'h3010, 8'h0, {32'h0, sp[i]});
      end
      rdc(16'h6040, 8'h1, 64'hfedc, 64'hffff);
   endtask
   task automatic t_read_only;
      logic [15:0] ix[6] = '{16'h6004, 16'h2000, 16'h6008, 16'h6030, 16'h6040, 16'h6300};
      logic [7:0] sb[6] = '{8'h0, 8'h0, 8'h0, 8'h1, 8'h1, 8'h1};
      for (int i = 0; i < 6; i++) begin
         wr(ix[i], sb[i], 32'h55, 1'b1);
      end
      rdc(16'h6300, 8'h1, 64'h4);
      acc(1'b0, 16'h5000, 8'h0, 32'h0, 1'b1);
   endtask
   task automatic t_cycle;
      int n;
      wr(16'h6200, 8'h0, 32'h2);
      n = 0;
      while (cycle_tick !== 1'b1 && n < 100) begin
         step(1);
         n++;
      end
      n = 0;
      do begin
         step(1);
         n++;
      end while (cycle_tick !== 1'b1 && n < 100);
      chk(n, 8);
      wr(16'h2200, 8'h0, 32'h0, 1'b1);
      wr(16'h1800, 8'h5, 32'hffff);
      rdc(16'h6200, 8'h0, 64'hffff, 64'hffff);
      rdc(16'h2200, 8'h0, 64'hffff, 64'hffff);
   endtask
   task automatic t_cam;
      wr(16'h6301, 8'h1, 32'h0f);
      rdc(16'h6301, 8'h1, 64'h0f);
      cam_hits = 8'h3c;
      cam_update = 1'b1;
      step(1);
      cam_update = 1'b0;
      rdc(16'h6300, 8'h1, 64'hc);
      rdc(16'h6300, 8'hfe, 64'h0);
      rdc(16'h6300, 8'h0, 64'h1);
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         tally_and_finish;
      end
   end
   initial begin
      step(8);
      rst = 1'b0;
      t_defaults;
      t_direction;
      t_scaling;
      t_preset;
      t_speed;
      t_read_only;
      t_cycle;
      t_cam;
      tally_and_finish;
   end
endmodule
bind encoder_position_object_set encoder_checker #(.TURN_BITS(TURN_BITS)) u_encoder_checker (
   .clock(clock), .rst(rst), .sensor_single(sensor_single), .sensor_turns(sensor_turns),
   .sensor_speed(sensor_speed), .sensor_accel(sensor_accel), .cam_update(cam_update),
   .cam_hits(cam_hits), .od_req(od_req), .od_write(od_write), .od_index(od_index),
   .od_sub(od_sub), .od_wdata(od_wdata), .od_ack(od_ack), .od_abort(od_abort),
   .od_rdata(od_rdata), .process_position(process_position), .wide_position(wide_position),
   .speed_out(speed_out), .cycle_tick(cycle_tick));
